/* File: design/srb_regbank.sv */
// module: sensor register space with frame bank and no-data control
`timescale 1ns/1ps
module srb_regbank #(
  parameter logic [15:0] PART_CODE          = 16'h5A3C, // arbitrary value
  parameter int unsigned NODATA_EXTRA_LINES = srb_pkg::SRB_NODATA_LINES
) (
  input  wire logic                       REF_CLK,
  input  wire logic                       RST_B,
  input  wire logic                       IDX_LOAD,
  input  wire logic [15:0]                IDX_VALUE,
  input  wire logic                       WR_STB,
  input  wire logic [7:0]                 WR_DATA,
  input  wire logic                       RD_STB,
  output logic      [7:0]                 RD_DATA,
  output logic                            RD_VALID,
  output logic      [15:0]                INDEX,
  input  wire logic                       FUSE_VALID,
  input  wire srb_pkg::srb_fuse_type      FUSE_DATA,
  input  wire logic                       VSYNC,
  input  wire logic                       LINE_STB,
  output srb_pkg::srb_frame_set_type      FRAME_SET,
  output logic                            FRAME_START,
  output logic                            NO_DATA
);
  import srb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (NODATA_EXTRA_LINES < 1 || NODATA_EXTRA_LINES > 255) begin : g_chk
    $error("NODATA_EXTRA_LINES must lie in 1..255");
  end

  localparam logic [16:0] EXTRA_LINES = 17'(NODATA_EXTRA_LINES);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0]  idx_r;
  logic [7:0]   rd_data_r;
  logic [7:0]   rd_nxt;
  logic         rd_valid_r;
  logic [23:0]  lot_r;
  logic [7:0]   wafer_r;
  logic [15:0]  die_r;
  logic [7:0]   frame_cnt_r;
  logic         soft_rst_r;
  logic         vs_s1_r;
  logic         vs_s2_r;
  logic         vs_s3_r;
  logic         vs_lvl_r;
  logic         vs_edge;
  logic         frame_start_r;
  logic [16:0]  gap_cnt_r;
  logic [16:0]  gap_nxt;
  logic         nodata_r;
  logic         fb_hit;
  logic [3:0]   fb_sel;
  logic         fb_wr;
  logic         gain_ok;
  logic [12:0]  fb_diff;
  logic         geom_change;
  logic [7:0]   shadow_r [SRB_FB_NUM];
  logic [7:0]   active_r [SRB_FB_NUM];
  srb_area_type area;

  ////////////////////////////////////////////////////////////////////////////
  // index area decode
  function automatic srb_area_type area_of(input logic [15:0] i);
    srb_area_type a;
    a = SRB_AREA_NONE;
    if (i <= SRB_CFG_LAST) begin
      a = SRB_AREA_CFG;
    end else if (i >= SRB_LIMIT_FIRST && i <= SRB_LIMIT_LAST) begin
      a = SRB_AREA_LIMIT;
    end else if (i >= SRB_MAKER_FIRST) begin
      a = SRB_AREA_MAKER;
    end
    return a;
  endfunction

  // full 16-bit index drives every decode
  assign area   = area_of(idx_r);
  assign fb_hit = (area == SRB_AREA_CFG) && (idx_r >= SRB_OFS_FB_BASE)
                  && (idx_r < SRB_OFS_FB_BASE + 16'(SRB_FB_NUM));
  assign fb_sel = 4'(idx_r - SRB_OFS_FB_BASE);

  ////////////////////////////////////////////////////////////////////////////
  // link index: load wins, then one step per byte moved
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      idx_r <= 16'h0000;
    end else if (IDX_LOAD) begin
      idx_r <= IDX_VALUE;
    end else if (WR_STB || RD_STB) begin
      idx_r <= idx_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write qualification: only frame bank entries and the reset bit
  // gain codes above the accept limit are dropped so the old code stays
  assign gain_ok = (fb_sel != SRB_FB_ANA_GAIN)
                   || (WR_DATA <= SRB_GAIN_MAX_ACCEPT);
  assign fb_wr   = WR_STB && !IDX_LOAD && fb_hit && gain_ok;

  // software reset is self clearing and reads back zero
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= WR_STB && !IDX_LOAD && (idx_r == SRB_OFS_SW_RESET)
                    && WR_DATA[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vertical sync: three stages, a change counts when stages two and three
  // agree, so a one-cycle glitch on the pin is not seen as a frame
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      vs_s1_r <= 1'b0;
      vs_s2_r <= 1'b0;
      vs_s3_r <= 1'b0;
    end else begin
      vs_s1_r <= VSYNC;
      vs_s2_r <= vs_s1_r;
      vs_s3_r <= vs_s2_r;
    end
  end

  assign vs_edge = (vs_s2_r == vs_s3_r) && vs_s3_r && !vs_lvl_r;

  // agreed level of the sync pin
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      vs_lvl_r <= 1'b0;
    end else if (vs_s2_r == vs_s3_r) begin
      vs_lvl_r <= vs_s3_r;
    end
  end

  // frame start pulse, one cycle after the agreed rising edge
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      frame_start_r <= 1'b0;
    end else begin
      frame_start_r <= vs_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame bank: shadow takes host bytes at once, working copy only on sync
  // a write in the sync cycle itself lands one frame later
  for (genvar e = 0; e < SRB_FB_NUM; e++) begin : g_fb
    always_ff @(posedge REF_CLK) begin
      if (!RST_B || soft_rst_r) begin
        shadow_r[e] <= 8'h00;
      end else if (fb_wr && fb_sel == 4'(e)) begin
        shadow_r[e] <= WR_DATA;
      end
    end

    always_ff @(posedge REF_CLK) begin
      if (!RST_B || soft_rst_r) begin
        active_r[e] <= 8'h00;
      end else if (vs_edge) begin
        active_r[e] <= shadow_r[e];
      end
    end

    assign fb_diff[e] = (shadow_r[e] != active_r[e]);
  end

  // only geometry entries open a gap; gain and integration never do
  assign geom_change = |(fb_diff & SRB_FB_GEOM_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // no-data gap in lines, measured from the sync that applies the change
  always_comb begin
    gap_nxt = gap_cnt_r;
    if (vs_edge && geom_change) begin
      if (shadow_r[SRB_FB_FAST_TRK][0]) begin
        gap_nxt = {1'b0, shadow_r[SRB_FB_INTEG_HI],
                   shadow_r[SRB_FB_INTEG_LO]} + EXTRA_LINES;
      end else begin
        gap_nxt = EXTRA_LINES;
      end
    end else if (LINE_STB && gap_cnt_r != 17'h00000) begin
      gap_nxt = gap_cnt_r - 17'h00001;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B || soft_rst_r) begin
      gap_cnt_r <= 17'h00000;
      nodata_r  <= 1'b0;
    end else begin
      gap_cnt_r <= gap_nxt;
      nodata_r  <= (gap_nxt != 17'h00000);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status area, updated by the device only
  always_ff @(posedge REF_CLK) begin
    if (!RST_B || soft_rst_r) begin
      frame_cnt_r <= SRB_RST_FRAME_CNT;
    end else if (vs_edge) begin
      frame_cnt_r <= frame_cnt_r + 8'h01;
    end
  end

  // fuse store bytes; an out-of-range wafer is pinned to the nearest bound
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      lot_r   <= 24'h000000;
      die_r   <= 16'h0000;
      wafer_r <= SRB_RST_WAFER;
    end else if (FUSE_VALID) begin
      lot_r <= FUSE_DATA.lot;
      die_r <= FUSE_DATA.die;
      if (FUSE_DATA.wafer < SRB_WAFER_MIN) begin
        wafer_r <= SRB_WAFER_MIN;
      end else if (FUSE_DATA.wafer > SRB_WAFER_MAX) begin
        wafer_r <= SRB_WAFER_MAX;
      end else begin
        wafer_r <= FUSE_DATA.wafer;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; anything not decoded answers zero
  always_comb begin
    rd_nxt = 8'h00;
    if (area == SRB_AREA_CFG) begin
      if (fb_hit) begin
        rd_nxt = shadow_r[fb_sel];
      end else begin
        unique case (idx_r)
          SRB_OFS_PART_HI:    rd_nxt = PART_CODE[15:8];
          SRB_OFS_PART_LO:    rd_nxt = PART_CODE[7:0];
          SRB_OFS_LOT_UP:     rd_nxt = lot_r[23:16];
          SRB_OFS_LOT_MID:    rd_nxt = lot_r[15:8];
          SRB_OFS_LOT_LOW:    rd_nxt = lot_r[7:0];
          SRB_OFS_WAFER:      rd_nxt = wafer_r;
          SRB_OFS_DIE_HI:     rd_nxt = die_r[15:8];
          SRB_OFS_DIE_LO:     rd_nxt = die_r[7:0];
          SRB_OFS_FRAME_CNT:  rd_nxt = frame_cnt_r;
          SRB_OFS_CFA_ORDER:  rd_nxt = SRB_RST_CFA_ORDER;
          SRB_OFS_BLACK_HI:   rd_nxt = SRB_RST_BLACK_HI & SRB_BLACK_HI_MASK;
          SRB_OFS_BLACK_LO:   rd_nxt = SRB_RST_BLACK_LO;
          SRB_OFS_GAIN_MAXLO: rd_nxt = SRB_GAIN_MAX_REPORT;
          SRB_OFS_PIX_D0LO:   rd_nxt = SRB_RST_PIX_D0LO;
          SRB_OFS_PIX_D1HI:   rd_nxt = SRB_RST_PIX_D1HI;
          SRB_OFS_PIX_D1LO:   rd_nxt = SRB_RST_PIX_D1LO;
          default: begin
            for (int d = 0; d < SRB_DESC_NUM; d++) begin
              if (idx_r == SRB_DESC_OFS[d]) begin
                rd_nxt = SRB_DESC_VAL[d];
              end
            end
          end
        endcase
      end
    end
  end

  // read byte is registered; index moves on the same edge
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= RD_STB && !IDX_LOAD;
      if (RD_STB && !IDX_LOAD) begin
        rd_data_r <= rd_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign RD_DATA     = rd_data_r;
  assign RD_VALID    = rd_valid_r;
  assign INDEX       = idx_r;
  assign FRAME_START = frame_start_r;
  assign NO_DATA     = nodata_r;

  // working settings, straight from the active copy flops
  assign FRAME_SET.ana_gain    = active_r[0];
  assign FRAME_SET.dig_gain    = {active_r[1], active_r[2]};
  assign FRAME_SET.integ_lines = {active_r[3], active_r[4]};
  assign FRAME_SET.binning     = active_r[5];
  assign FRAME_SET.v_subsample = active_r[6];
  assign FRAME_SET.orientation = active_r[7];
  assign FRAME_SET.v_roi_start = {active_r[8], active_r[9]};
  assign FRAME_SET.v_roi_end   = {active_r[10], active_r[11]};
  assign FRAME_SET.fast_track  = active_r[12];

endmodule

/* File: design/srb_pkg.sv */
// package: constants and types for the sensor register bank
package srb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // index space areas
  localparam logic [15:0] SRB_CFG_LAST    = 16'h0FFF;
  localparam logic [15:0] SRB_LIMIT_FIRST = 16'h1000;
  localparam logic [15:0] SRB_LIMIT_LAST  = 16'h1FFF;
  localparam logic [15:0] SRB_MAKER_FIRST = 16'h3000;
  localparam logic [15:0] SRB_STATUS_LAST = 16'h001B;

  typedef enum logic [1:0] {
    SRB_AREA_CFG   = 2'b00,
    SRB_AREA_LIMIT = 2'b01,
    SRB_AREA_MAKER = 2'b10,
    SRB_AREA_NONE  = 2'b11
  } srb_area_type;

  ////////////////////////////////////////////////////////////////////////////
  // status, description, reset and frame bank offsets
  localparam logic [15:0] SRB_OFS_PART_HI    = 16'h0000;
  localparam logic [15:0] SRB_OFS_PART_LO    = 16'h0001;
  localparam logic [15:0] SRB_OFS_LOT_UP     = 16'h0004;
  localparam logic [15:0] SRB_OFS_LOT_MID    = 16'h0005;
  localparam logic [15:0] SRB_OFS_LOT_LOW    = 16'h0006;
  localparam logic [15:0] SRB_OFS_WAFER      = 16'h0007;
  localparam logic [15:0] SRB_OFS_DIE_HI     = 16'h000D;
  localparam logic [15:0] SRB_OFS_DIE_LO     = 16'h000E;
  localparam logic [15:0] SRB_OFS_FRAME_CNT  = 16'h0018;
  localparam logic [15:0] SRB_OFS_CFA_ORDER  = 16'h0019;
  localparam logic [15:0] SRB_OFS_BLACK_HI   = 16'h001A;
  localparam logic [15:0] SRB_OFS_BLACK_LO   = 16'h001B;
  localparam logic [15:0] SRB_OFS_GAIN_MAXLO = 16'h0087;
  localparam logic [15:0] SRB_OFS_SW_RESET   = 16'h0103;
  localparam logic [15:0] SRB_OFS_FB_BASE    = 16'h0160;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] SRB_RST_FRAME_CNT = 8'hFF;
  localparam logic [7:0] SRB_RST_CFA_ORDER = 8'h01;
  localparam logic [7:0] SRB_RST_BLACK_HI  = 8'h00;
  localparam logic [7:0] SRB_RST_BLACK_LO  = 8'h40;
  localparam logic [7:0] SRB_RST_WAFER     = 8'h01;
  localparam logic [7:0] SRB_BLACK_HI_MASK = 8'h03;

  // fixed description bytes, index -> value, unlisted bytes read zero
  localparam int SRB_DESC_NUM = 23;
  localparam logic [15:0] SRB_DESC_OFS [SRB_DESC_NUM] = '{
    16'h0040, 16'h0041, 16'h0042, 16'h0043, 16'h0044, 16'h0045,
    16'h0046, 16'h0047, 16'h0081, 16'h0082, 16'h0085, 16'h0086,
    16'h0088, 16'h0089, 16'h008A, 16'h008C, 16'h008E, 16'h0090,
    16'h0091, 16'h0092, 16'h00C0, 16'h00C1, 16'h00C2};
  localparam logic [7:0] SRB_DESC_VAL [SRB_DESC_NUM] = '{
    8'h01, 8'h12, 8'h5C, 8'hD0, 8'h10, 8'h02,
    8'h59, 8'hA0, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'hFF,
    8'hFF, 8'h01, 8'h01, 8'h01, 8'h0A};
  localparam logic [15:0] SRB_OFS_PIX_D0LO = 16'h00C3;
  localparam logic [15:0] SRB_OFS_PIX_D1HI = 16'h00C4;
  localparam logic [15:0] SRB_OFS_PIX_D1LO = 16'h00C5;
  localparam logic [7:0]  SRB_RST_PIX_D0LO = 8'h08;
  localparam logic [7:0]  SRB_RST_PIX_D1HI = 8'h0A;
  localparam logic [7:0]  SRB_RST_PIX_D1LO = 8'h0A;

  ////////////////////////////////////////////////////////////////////////////
  // analogue gain limits and wafer range
  localparam logic [7:0] SRB_GAIN_MAX_REPORT = 8'hE0;
  localparam logic [7:0] SRB_GAIN_MAX_ACCEPT = 8'hE8;
  localparam logic [7:0] SRB_WAFER_MIN       = 8'h01;
  localparam logic [7:0] SRB_WAFER_MAX       = 8'h19;

  ////////////////////////////////////////////////////////////////////////////
  // frame bank entries, offset from SRB_OFS_FB_BASE
  localparam int SRB_FB_NUM = 13;
  localparam logic [3:0] SRB_FB_ANA_GAIN  = 4'h0;
  localparam logic [3:0] SRB_FB_INTEG_HI  = 4'h3;
  localparam logic [3:0] SRB_FB_INTEG_LO  = 4'h4;
  localparam logic [3:0] SRB_FB_FAST_TRK  = 4'hC;
  // binning, v subsample, orientation, v roi start/end
  localparam logic [12:0] SRB_FB_GEOM_MASK = 13'h0FE0;
  localparam int unsigned SRB_NODATA_LINES = 20;

  typedef struct packed {
    logic [23:0] lot;
    logic [7:0]  wafer;
    logic [15:0] die;
  } srb_fuse_type;

  typedef struct packed {
    logic [7:0]  ana_gain;
    logic [15:0] dig_gain;
    logic [15:0] integ_lines;
    logic [7:0]  binning;
    logic [7:0]  v_subsample;
    logic [7:0]  orientation;
    logic [15:0] v_roi_start;
    logic [15:0] v_roi_end;
    logic [7:0]  fast_track;
  } srb_frame_set_type;

endpackage

/* File: verif/srb_regbank_assertions.sv */
// checker: link port, frame sync and gap timing of the register bank
`timescale 1ns/1ps
module srb_regbank_chk
  import srb_pkg::*;
#(
  parameter logic [15:0] PART_CODE          = 16'h5A3C, // arbitrary value
  parameter int unsigned NODATA_EXTRA_LINES = 20
) (
  input wire logic                       REF_CLK,
  input wire logic                       RST_B,
  input wire logic                       IDX_LOAD,
  input wire logic [15:0]                IDX_VALUE,
  input wire logic                       WR_STB,
  input wire logic [7:0]                 WR_DATA,
  input wire logic                       RD_STB,
  input wire logic [7:0]                 RD_DATA,
  input wire logic                       RD_VALID,
  input wire logic [15:0]                INDEX,
  input wire logic                       FUSE_VALID,
  input wire srb_pkg::srb_fuse_type      FUSE_DATA,
  input wire logic                       VSYNC,
  input wire logic                       LINE_STB,
  input wire srb_pkg::srb_frame_set_type FRAME_SET,
  input wire logic                       FRAME_START,
  input wire logic                       NO_DATA
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  // a strobe only counts when no index load shares its cycle
  logic take_rd;
  assign take_rd = RD_STB && !IDX_LOAD;

  // a software reset clears the working copy two edges after its write
  logic soft_wr;
  assign soft_wr = WR_STB && !IDX_LOAD && INDEX == SRB_OFS_SW_RESET
                   && WR_DATA[0];

  ////////////////////////////////////////
  // link byte port
  chk_rd_answer: assert property (take_rd |=> RD_VALID)
    else $error("read strobe without valid");
  chk_rd_quiet: assert property (!take_rd |=> !RD_VALID)
    else $error("valid without read strobe");
  chk_idx_load: assert property (IDX_LOAD |=> INDEX == $past(IDX_VALUE))
    else $error("index not loaded");
  chk_idx_step: assert property ((WR_STB || RD_STB) && !IDX_LOAD
    |=> INDEX == $past(INDEX) + 16'h0001) else $error("index not stepped");
  chk_idx_hold: assert property (!IDX_LOAD && !WR_STB && !RD_STB
    |=> $stable(INDEX)) else $error("index moved while idle");
  chk_area_zero: assert property (take_rd && INDEX >= SRB_LIMIT_FIRST
    |=> RD_DATA == 8'h00) else $error("upper area read not zero");
  chk_wafer_range: assert property (take_rd && INDEX == SRB_OFS_WAFER
    |=> RD_DATA inside {[SRB_WAFER_MIN:SRB_WAFER_MAX]})
    else $error("wafer byte out of range");
  chk_gain_report: assert property (take_rd &&
    INDEX == SRB_OFS_GAIN_MAXLO |=> RD_DATA == SRB_GAIN_MAX_REPORT)
    else $error("max gain report wrong");

  ////////////////////////////////////////
  // frame sync and gap
  chk_set_on_sync: assert property ($changed(FRAME_SET)
    |-> FRAME_START || $past(soft_wr, 2))
    else $error("settings changed mid frame");
  chk_start_pulse: assert property (FRAME_START |=> !FRAME_START)
    else $error("frame start longer than one cycle");
  chk_gap_start: assert property ($rose(NO_DATA) |-> FRAME_START)
    else $error("gap began off the sync");
  chk_gap_end: assert property ($fell(NO_DATA)
    |-> $past(LINE_STB) || $past(LINE_STB, 2))
    else $error("gap ended without a line");

  cover property (take_rd);
  cover property ($rose(NO_DATA));
  cover property ($fell(NO_DATA));
  cover property (soft_wr);
endmodule

bind srb_regbank srb_regbank_chk #(.PART_CODE(PART_CODE),
  .NODATA_EXTRA_LINES(NODATA_EXTRA_LINES)) i_srb_regbank_chk (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .IDX_LOAD(IDX_LOAD),
  .IDX_VALUE(IDX_VALUE), .WR_STB(WR_STB), .WR_DATA(WR_DATA),
  .RD_STB(RD_STB), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .INDEX(INDEX), .FUSE_VALID(FUSE_VALID), .FUSE_DATA(FUSE_DATA),
  .VSYNC(VSYNC), .LINE_STB(LINE_STB), .FRAME_SET(FRAME_SET),
  .FRAME_START(FRAME_START), .NO_DATA(NO_DATA));

/* File: verif/srb_host_model.sv */
// host model: drives the link byte port of the register bank
`timescale 1ns/1ps
module srb_host_model (
  input  wire logic        clk,
  input  wire logic [7:0]  rd_data,
  output logic             idx_load,
  output logic [15:0]      idx_value,
  output logic             wr_stb,
  output logic [7:0]       wr_data,
  output logic             rd_stb
);
  // idle link at time zero
  initial begin
    idx_load = 1'b0;
    idx_value = 16'h0000;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
  end

  // the load wins over strobes, so it gets a cycle of its own
  task automatic point(input logic [15:0] a);
    @(posedge clk);
    idx_load <= 1'b1;
    idx_value <= a;
    @(posedge clk);
    idx_load <= 1'b0;
  endtask

  // back-to-back burst, high byte first
  task automatic wr(input logic [15:0] a, input logic [63:0] d, input int n);
    point(a);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      wr_stb <= 1'b1;
      wr_data <= d[i*8 +: 8];
    end
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // each byte is taken one cycle after its strobe edge
  task automatic rd(input logic [15:0] a, input int n, output logic [63:0] q);
    q = '0;
    point(a);
    @(posedge clk);
    rd_stb <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (i == n - 1) rd_stb <= 1'b0;
      #1;
      q = {q[55:0], rd_data};
    end
  endtask
endmodule

/* File: verif/tb_top.sv */
// testbench: register reads, frame bank timing and no-output gaps
`timescale 1ns/1ps
module tb_top;
  import srb_pkg::*;
  typedef struct { logic [15:0] a; logic [7:0] d; } srb_row_type;
  localparam logic [15:0] PART = 16'hC3A5; // arbitrary value

  logic              ref_clk, rst_b, idx_load, wr_stb, rd_stb, rd_valid;
  logic              fuse_valid, vsync, line_stb, frame_start, no_data;
  logic [15:0]       idx_value, index;
  logic [7:0]        wr_data, rd_data;
  logic [63:0]       q;
  srb_fuse_type      fuse_data;
  srb_frame_set_type frame_set;
  int                n_fail, cmp_count, n;

  // index and expected byte after a write of FF was ignored
  srb_row_type rows [26] = '{'{16'h0000, 8'hC3}, '{16'h0001, 8'hA5},
    '{16'h0004, 8'hAB}, '{16'h0005, 8'hCD}, '{16'h0006, 8'hEF},
    '{16'h0007, 8'h19}, '{16'h000D, 8'h12}, '{16'h000E, 8'h34},
    '{16'h0018, 8'hFF}, '{16'h0019, 8'h01}, '{16'h001A, 8'h00},
    '{16'h001B, 8'h40}, '{16'h0041, 8'h12}, '{16'h0043, 8'hD0},
    '{16'h0047, 8'hA0}, '{16'h0086, 8'h00}, '{16'h0087, 8'hE0},
    '{16'h0089, 8'h01}, '{16'h00C3, 8'h08}, '{16'h00C5, 8'h0A},
    '{16'h0080, 8'h00}, '{16'h1000, 8'h00}, '{16'h1FFF, 8'h00},
    '{16'h2000, 8'h00}, '{16'h3000, 8'h00}, '{16'hFFFF, 8'h00}};

  srb_regbank #(.PART_CODE(PART)) i_srb_regbank (.REF_CLK(ref_clk),
    .RST_B(rst_b), .IDX_LOAD(idx_load), .IDX_VALUE(idx_value),
    .WR_STB(wr_stb), .WR_DATA(wr_data), .RD_STB(rd_stb),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .INDEX(index),
    .FUSE_VALID(fuse_valid), .FUSE_DATA(fuse_data), .VSYNC(vsync),
    .LINE_STB(line_stb), .FRAME_SET(frame_set),
    .FRAME_START(frame_start), .NO_DATA(no_data));
  srb_host_model i_srb_host_model (.clk(ref_clk), .rd_data(rd_data),
    .idx_load(idx_load), .idx_value(idx_value), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////
  task automatic cmp_v(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cmp_f(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // three-cycle sync pulse; the pin is synchronised, so wait bounded
  task automatic frame;
    int w;
    @(posedge ref_clk);
    vsync <= 1'b1;
    repeat (3) @(posedge ref_clk);
    vsync <= 1'b0;
    for (w = 0; w < 20 && frame_start !== 1'b1; w++) begin
      @(posedge ref_clk);
      #1;
    end
    cmp_f("frame start", 1'b1, frame_start);
  endtask

  // spaced line strobes until the gap closes, counting them
  task automatic gap(output int c);
    for (c = 0; c < 60 && no_data === 1'b1; c++) begin
      @(posedge ref_clk);
      line_stb <= 1'b1;
      @(posedge ref_clk);
      line_stb <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
    end
  endtask

  // watchdog: the whole run needs well under 5000 cycles
  initial begin
    #100us;
    n_fail++;
    finish_test;
  end

  ////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    vsync = 1'b0;
    line_stb = 1'b0;
    fuse_valid = 1'b0;
    fuse_data = '0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    fuse_valid <= 1'b1;
    fuse_data <= '{lot: 24'hABCDEF, wafer: 8'h30, die: 16'h1234};
    @(posedge ref_clk);
    fuse_valid <= 1'b0;
    foreach (rows[i]) begin
      i_srb_host_model.wr(rows[i].a, 64'hFF, 1);
      i_srb_host_model.rd(rows[i].a, 1, q);
      cmp_v("row", {8'h00, rows[i].d}, {8'h00, q[7:0]});
    end
    // burst: gain 40, digital gain 0100, integration 0005
    i_srb_host_model.wr(16'h0160, 64'h40_0100_0005, 5);
    #1;
    cmp_v("index", 16'h0165, index);
    i_srb_host_model.rd(16'h0160, 5, q);
    cmp_v("shadow", 16'h0005, q[15:0]);
    cmp_v("held gain", 16'h0000, {8'h00, frame_set.ana_gain});
    frame();
    cmp_v("gain", 16'h0040, {8'h00, frame_set.ana_gain});
    cmp_v("integ", 16'h0005, frame_set.integ_lines);
    cmp_v("dig gain", 16'h0100, frame_set.dig_gain);
    cmp_f("no gap", 1'b0, no_data);
    i_srb_host_model.rd(SRB_OFS_FRAME_CNT, 1, q);
    cmp_v("count", 16'h0000, {8'h00, q[7:0]});
    // gain code above the accepted maximum is dropped
    i_srb_host_model.wr(16'h0160, 64'hE9, 1);
    i_srb_host_model.rd(16'h0160, 1, q);
    cmp_v("gain E9", 16'h0040, {8'h00, q[7:0]});
    i_srb_host_model.wr(16'h0160, 64'hE8, 1);
    i_srb_host_model.rd(16'h0160, 1, q);
    cmp_v("gain E8", 16'h00E8, {8'h00, q[7:0]});
    // binning change: plain gap
    i_srb_host_model.wr(16'h0165, 64'h02, 1);
    frame();
    cmp_f("gap", 1'b1, no_data);
    cmp_v("binning", 16'h0002, {8'h00, frame_set.binning});
    gap(n);
    cmp_v("gap lines", 16'd20, 16'(n));
    // subsample change with fast tracking: integration plus twenty
    i_srb_host_model.wr(16'h016C, 64'h01, 1);
    i_srb_host_model.wr(16'h0166, 64'h01, 1);
    frame();
    gap(n);
    cmp_v("fast lines", 16'd25, 16'(n));
    frame();
    cmp_f("idle frame", 1'b0, no_data);
    // reset in mid-run
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    cmp_v("reset gain", 16'h0000, {8'h00, frame_set.ana_gain});
    i_srb_host_model.rd(SRB_OFS_FRAME_CNT, 1, q);
    cmp_v("reset count", 16'h00FF, {8'h00, q[7:0]});
    // software reset: working copy and frame counter back to reset values
    i_srb_host_model.wr(16'h0160, 64'h40, 1);
    frame();
    i_srb_host_model.wr(SRB_OFS_SW_RESET, 64'h01, 1);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_v("soft gain", 16'h0000, {8'h00, frame_set.ana_gain});
    i_srb_host_model.rd(SRB_OFS_FRAME_CNT, 1, q);
    cmp_v("soft count", 16'h00FF, {8'h00, q[7:0]});
    i_srb_host_model.rd(SRB_OFS_SW_RESET, 1, q);
    cmp_v("reset byte", 16'h0000, {8'h00, q[7:0]});
    finish_test;
  end
endmodule
